// ---- hdl/mps_meas_if.sv ----
// Scaled measurements passed from the scaler to the supervisor.
// Assumes one producer and one consumer in the mclk domain.
`timescale 1ns/10ps
`default_nettype none
interface mps_meas_if;
  import mps_pkg::*;
  logic signed [15:0] angle_cdeg;
  logic [11:0] speed_rpm;
  logic cmd_ccw;
  logic [16:0] vbus_mv;
  logic signed [15:0] cur_ma [PHASE_N];
  modport src (output angle_cdeg, output speed_rpm, output cmd_ccw, output vbus_mv, output cur_ma);
  modport dst (input angle_cdeg, input speed_rpm, input cmd_ccw, input vbus_mv, input cur_ma);
endinterface
`default_nettype wire

// ---- hdl/mps_pkg.sv ----
// Constants shared by the motor protection and scaling block.
// Assumes 12-bit converter codes and a 100 MHz mclk.
package mps_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MON_PERIOD_US = 50;
  localparam int MON_CYCLES = (MON_PERIOD_US * 1000) / CLK_PERIOD_NS;

  // ****************************************
  // Converter code points
  // ****************************************
  localparam logic [11:0] CODE_CW_ZERO = 12'h7ff;
  localparam logic [11:0] CODE_CCW_ZERO = 12'h800;
  localparam logic [11:0] CODE_FULL = 12'hfff;
  localparam logic [31:0] CODE_HALF_SPAN = 32'h0000_07ff;
  localparam logic [31:0] CODE_FULL_SPAN = 32'h0000_0fff;

  // ****************************************
  // Scale end points (centidegree, rpm, mV, mA)
  // ****************************************
  localparam logic [31:0] ANGLE_FULL_CDEG = 32'd18000;
  localparam logic [31:0] SPEED_FULL_RPM = 32'd2000;
  localparam logic [31:0] VBUS_FULL_MV = 32'd111000;
  localparam logic [31:0] CUR_SPAN_MA = 32'd25000;
  localparam logic signed [31:0] CUR_OFFSET_MA = 32'sd12500;

  // ****************************************
  // Protection limits
  // ****************************************
  localparam logic [15:0] OC_LIMIT_MA = 16'd3820;
  localparam logic [16:0] OV_LIMIT_MV = 17'd28000;
  localparam logic [16:0] UV_LIMIT_MV = 17'd14000;
  localparam logic [15:0] OS_LIMIT_RPM = 16'd3000;
  localparam logic signed [15:0] POS_DEADBAND_CNT = 16'sd1;

  // ****************************************
  // Fault cause bit positions and system state
  // ****************************************
  localparam int FLT_OC = 0;
  localparam int FLT_OV = 1;
  localparam int FLT_UV = 2;
  localparam int FLT_OS = 3;
  localparam int FLT_W = 4;
  localparam int GATE_N = 6;
  localparam int PHASE_N = 2;

  typedef enum logic [1:0] {ST_INACTIVE, ST_ACTIVE, ST_ERROR} mps_state_t;

endpackage

// ---- hdl/mps_scale.sv ----
// Linear scaling of converter codes into engineering units.
// Assumes codes are held stable by the caller; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module mps_scale
  import mps_pkg::*;
(
  // Converter codes
  input wire logic [11:0] cmd_code,
  input wire logic [11:0] vbus_code,
  input wire logic [11:0] cur_code [PHASE_N],
  // Scaled results
  mps_meas_if.src meas
);
  logic ccw;
  logic [31:0] off;
  logic [31:0] ang_mag;
  logic [31:0] spd_mag;
  logic [31:0] vbus_full;

  // ****************************************
  // Command potentiometer: lower half CW, upper half CCW
  // ****************************************
  assign ccw = cmd_code[11];
  assign off = ccw ? 32'(cmd_code - CODE_CCW_ZERO) : 32'(CODE_CW_ZERO - cmd_code);
  assign ang_mag = (off * ANGLE_FULL_CDEG) / CODE_HALF_SPAN;
  assign spd_mag = (off * SPEED_FULL_RPM) / CODE_HALF_SPAN;
  assign meas.angle_cdeg = ccw ? -16'(ang_mag) : 16'(ang_mag);
  assign meas.speed_rpm = 12'(spd_mag);
  assign meas.cmd_ccw = ccw;

  // ****************************************
  // Bus voltage, full code is full scale
  // ****************************************
  assign vbus_full = (32'(vbus_code) * VBUS_FULL_MV) / CODE_FULL_SPAN;
  assign meas.vbus_mv = 17'(vbus_full);

  // ****************************************
  // Phase currents, mid code is zero amps
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < PHASE_N; g++)
    begin : g_cur
      logic signed [31:0] pos;
      assign pos = signed'((32'(cur_code[g]) * CUR_SPAN_MA) / CODE_FULL_SPAN);
      assign meas.cur_ma[g] = 16'(pos - CUR_OFFSET_MA);
    end
  endgenerate
endmodule
`default_nettype wire

// ---- hdl/mps_tick.sv ----
// Free-running monitoring tick generator.
// Assumes mclk runs continuously; pulse is one cycle wide.
`timescale 1ns/10ps
`default_nettype none
module mps_tick #(
  parameter int unsigned PERIOD = 5000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Tick
  output logic tick
);
  logic [15:0] cnt_r;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end
    else if (cnt_r == 16'(PERIOD - 1))
    begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/mps_top.sv ----
// Motor supervisor: scales converter readings, decodes the start switch,
// and shuts the inverter gates down on a protection fault.
// Assumes all inputs are synchronous to mclk.
//
// How it works
// - Phase current over 3.82 A disables gates
// - Bus voltage over 28 V disables gates
// - Bus voltage under 14 V disables gates
// - Speed over 3000 rpm disables gates
// - Fault falling edge or short tri-states PWM
// - Switch sampled low requests motor start
// - Switch going high stops; host may too
// - CW position: 0x7ff..0x000 maps 0..180 deg
// - CCW position: 0x800..0xfff maps 0..-180 deg
// - CW speed: 0x7ff..0x000 maps 0..2000 rpm
// - CCW speed: 0x800..0xfff maps 0..2000 rpm
// - Bus code 0x000..0xfff maps 0..111 V
// - Scaled bus voltage feeds the vbus_mv output and limits
// - Current code maps -12.5 A..+12.5 A
// - Position error within one count reads zero
`timescale 1ns/10ps
`default_nettype none
module mps_top
  import mps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MON_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Converter results
  input wire logic adc_valid,
  input wire logic [11:0] command_input_channel,
  input wire logic [11:0] bus_voltage_channel,
  input wire logic [11:0] phase_u_current_channel,
  input wire logic [11:0] phase_w_current_channel,
  // Motion feedback
  input wire logic signed [15:0] rotor_speed_rpm,
  input wire logic signed [15:0] pos_err_cnt,
  // Operator and host controls
  input wire logic start_stop_switch,
  input wire logic host_start,
  input wire logic host_stop,
  input wire logic fault_clear,
  // Hardware fault inputs
  input wire logic ext_oc_n,
  input wire logic short_detect,
  // Gate drive
  output logic [GATE_N-1:0] gate_en,
  output logic pwm_hiz,
  // Status
  output logic motor_run,
  output logic [1:0] sys_state,
  output logic [FLT_W-1:0] fault_flags,
  output logic mon_tick,
  // Scaled values
  output logic signed [15:0] cmd_angle_cdeg,
  output logic [11:0] cmd_speed_rpm,
  output logic cmd_ccw,
  output logic [16:0] vbus_mv,
  output logic signed [15:0] iu_ma,
  output logic signed [15:0] iw_ma,
  output logic signed [15:0] pos_err_db
);

  // ****************************************
  // Converter capture and scaling
  // ****************************************
  logic [11:0] cmd_code_r;
  logic [11:0] vbus_code_r;
  logic [11:0] cur_code_r [PHASE_N];
  logic tick;

  mps_meas_if meas ();

  // Hold the last converted codes so scaling sees stable inputs
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_code_r <= CODE_CW_ZERO;
      vbus_code_r <= 12'h000;
      cur_code_r[0] <= CODE_CCW_ZERO;
      cur_code_r[1] <= CODE_CCW_ZERO;
    end
    else if (adc_valid)
    begin
      cmd_code_r <= command_input_channel;
      vbus_code_r <= bus_voltage_channel;
      cur_code_r[0] <= phase_u_current_channel;
      cur_code_r[1] <= phase_w_current_channel;
    end
  end

  mps_scale u_scale (
    .cmd_code(cmd_code_r),
    .vbus_code(vbus_code_r),
    .cur_code(cur_code_r),
    .meas(meas.src)
  );

  mps_tick #(
    .PERIOD(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .arst_n(arst_n),
    .tick(tick)
  );

  // ****************************************
  // Registered scaled outputs
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_angle_cdeg <= 16'sh0000;
      cmd_speed_rpm <= 12'h000;
      cmd_ccw <= 1'b0;
      vbus_mv <= 17'h00000;
      iu_ma <= 16'sh0000;
      iw_ma <= 16'sh0000;
      mon_tick <= 1'b0;
    end
    else
    begin
      cmd_angle_cdeg <= meas.angle_cdeg;
      cmd_speed_rpm <= meas.speed_rpm;
      cmd_ccw <= meas.cmd_ccw;
      vbus_mv <= meas.vbus_mv;
      iu_ma <= meas.cur_ma[0];
      iw_ma <= meas.cur_ma[1];
      mon_tick <= tick;
    end
  end

  // ****************************************
  // Position dead band
  // ****************************************
  // Suppresses hunting when the rotor sits one count off target
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      pos_err_db <= 16'sh0000;
    else if (pos_err_cnt >= -POS_DEADBAND_CNT && pos_err_cnt <= POS_DEADBAND_CNT)
      pos_err_db <= 16'sh0000;
    else
      pos_err_db <= pos_err_cnt;
  end

  // ****************************************
  // Protection checks, evaluated on the tick only
  // ****************************************
  logic signed [16:0] iv_ma;
  logic [15:0] iu_abs;
  logic [15:0] iw_abs;
  logic [16:0] iv_abs;
  logic [15:0] spd_abs;
  logic oc_hit;
  logic ov_hit;
  logic uv_hit;
  logic os_hit;
  logic [FLT_W-1:0] flt_set;

  // V phase is not sensed; it is implied by the other two
  assign iv_ma = -(17'(meas.cur_ma[0]) + 17'(meas.cur_ma[1]));
  assign iu_abs = meas.cur_ma[0][15] ? 16'(-meas.cur_ma[0]) : 16'(meas.cur_ma[0]);
  assign iw_abs = meas.cur_ma[1][15] ? 16'(-meas.cur_ma[1]) : 16'(meas.cur_ma[1]);
  assign iv_abs = iv_ma[16] ? 17'(-iv_ma) : 17'(iv_ma);
  assign spd_abs = rotor_speed_rpm[15] ? 16'(-rotor_speed_rpm) : 16'(rotor_speed_rpm);

  assign oc_hit = (iu_abs > OC_LIMIT_MA) || (iw_abs > OC_LIMIT_MA) || (iv_abs > 17'(OC_LIMIT_MA));
  assign ov_hit = meas.vbus_mv > OV_LIMIT_MV;
  assign uv_hit = meas.vbus_mv < UV_LIMIT_MV;
  assign os_hit = spd_abs > OS_LIMIT_RPM;

  always_comb
  begin
    flt_set = '0;
    if (tick)
    begin
      flt_set[FLT_OC] = oc_hit;
      flt_set[FLT_OV] = ov_hit;
      flt_set[FLT_UV] = uv_hit;
      flt_set[FLT_OS] = os_hit;
    end
  end

  // Set wins over clear so a fault on the clearing cycle is kept
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      fault_flags <= '0;
    else
      fault_flags <= (fault_clear ? '0 : fault_flags) | flt_set;
  end

  // ****************************************
  // Hardware emergency stop
  // ****************************************
  logic ext_oc_prev_r;
  logic hiz_set;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      ext_oc_prev_r <= 1'b1;
    else
      ext_oc_prev_r <= ext_oc_n;
  end

  assign hiz_set = (ext_oc_prev_r && !ext_oc_n) || short_detect;

  // Not tick-gated: the hardware path must act within one cycle
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      pwm_hiz <= 1'b0;
    else
      pwm_hiz <= (fault_clear ? 1'b0 : pwm_hiz) | hiz_set;
  end

  // ****************************************
  // Start and stop requests
  // ****************************************
  logic sw_smp_r;
  logic sw_prev_r;
  logic sw_start;
  logic sw_stop;

  // The switch is polled on the tick, like a main loop would
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sw_smp_r <= 1'b1;
      sw_prev_r <= 1'b1;
    end
    else if (tick)
    begin
      sw_smp_r <= start_stop_switch;
      sw_prev_r <= sw_smp_r;
    end
  end

  assign sw_start = !sw_smp_r;
  // One-cycle event in the cycle after the sample, so a stale switch edge cannot cancel a later host start
  assign sw_stop = mon_tick && sw_smp_r && !sw_prev_r;

  // ****************************************
  // System state
  // ****************************************
  mps_state_t state_r;
  logic any_fault;

  assign any_fault = (|fault_flags) || (|flt_set) || pwm_hiz || hiz_set;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      state_r <= ST_INACTIVE;
    else
    begin
      unique case (state_r)
        ST_INACTIVE:
        begin
          if (any_fault)
            state_r <= ST_ERROR;
          else if (host_start || (sw_start && !host_stop))
            state_r <= ST_ACTIVE;
        end
        ST_ACTIVE:
        begin
          if (any_fault)
            state_r <= ST_ERROR;
          else if (host_stop || sw_stop)
            state_r <= ST_INACTIVE;
        end
        ST_ERROR:
        begin
          // Leave only once the clear has emptied every latch
          if (fault_clear && !(|flt_set) && !hiz_set)
            state_r <= ST_INACTIVE;
        end
      endcase
    end
  end

  // ****************************************
  // Gate drive and status outputs
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      motor_run <= 1'b0;
      sys_state <= 2'(ST_INACTIVE);
    end
    else
    begin
      motor_run <= (state_r == ST_ACTIVE) && !any_fault;
      sys_state <= 2'(state_r);
    end
  end

  genvar g;
  generate
    for (g = 0; g < GATE_N; g++)
    begin : g_gate
      always_ff @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
          gate_en[g] <= 1'b0;
        else
          gate_en[g] <= (state_r == ST_ACTIVE) && !any_fault;
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- verification/mps_board_model.sv ----
// Board model: sense-channel codes, start switch and fault lines.
// Assumes the bench changes levels on falling mclk edges.
`timescale 1ns/10ps
`default_nettype none
module mps_board_model (
  // Clock
  input wire logic mclk,
  // Converter results
  output logic adc_valid,
  output logic [11:0] cmd_code,
  output logic [11:0] vbus_code,
  output logic [11:0] iu_code,
  output logic [11:0] iw_code,
  // Switch and fault lines
  output logic sw,
  output logic oc_n,
  output logic shrt
);
  // Strobe spacing; a larger gap models a slow converter
  int gap = 0;
  int cnt = 0;
  initial
  begin
    {cmd_code, vbus_code, iu_code, iw_code} = {12'h7ff, 12'h2e2, 12'h800, 12'h7ff};
    sw = 1'b1;
    oc_n = 1'b1;
    shrt = 1'b0;
    adc_valid = 1'b0;
  end
  always @(negedge mclk)
  begin
    adc_valid <= (cnt == 0);
    cnt <= (cnt >= gap) ? 0 : cnt + 1;
  end
  task automatic put(input logic [11:0] c, input logic [11:0] v, input logic [11:0] u, input logic [11:0] w);
    @(negedge mclk);
    {cmd_code, vbus_code, iu_code, iw_code} = {c, v, u, w};
  endtask
endmodule
`default_nettype wire

// ---- verification/mps_top_assertions.sv ----
// Port-level assertions for the motor supervisor.
// Assumes one mclk domain; bound onto every mps_top instance.
`timescale 1ns/10ps
`default_nettype none
module mps_top_assertions
  import mps_pkg::*;
#(
  parameter int TICK_CYCLES = 20
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Watched inputs
  input wire logic fault_clear,
  input wire logic ext_oc_n,
  input wire logic short_detect,
  input wire logic signed [15:0] rotor_speed_rpm,
  input wire logic signed [15:0] pos_err_cnt,
  // Watched outputs
  input wire logic [GATE_N-1:0] gate_en,
  input wire logic pwm_hiz,
  input wire logic motor_run,
  input wire logic [1:0] sys_state,
  input wire logic [FLT_W-1:0] fault_flags,
  input wire logic mon_tick,
  input wire logic [16:0] vbus_mv,
  input wire logic signed [15:0] iu_ma,
  input wire logic signed [15:0] iw_ma,
  input wire logic signed [15:0] pos_err_db
);
  // ****************************************
  // Protection and gating
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  a_oc_trip: assert property (
    mon_tick && (iu_ma > 16'sd3820 || iu_ma < -16'sd3820 || iw_ma > 16'sd3820 || iw_ma < -16'sd3820)
    |-> fault_flags[FLT_OC] && gate_en == '0) else $error("over-current not latched");
  a_ov_trip: assert property (
    mon_tick && vbus_mv > 17'd28000 |-> fault_flags[FLT_OV]) else $error("over-voltage not latched");
  a_uv_trip: assert property (
    mon_tick && vbus_mv < 17'd14000 |-> fault_flags[FLT_UV] && gate_en == '0) else $error("under-voltage missed");
  a_os_trip: assert property (
    mon_tick && ($past(rotor_speed_rpm) > 16'sd3000 || $past(rotor_speed_rpm) < -16'sd3000)
    |-> fault_flags[FLT_OS]) else $error("over-speed not latched");
  a_flag_on_tick: assert property (
    (fault_flags & ~$past(fault_flags)) != '0 |-> mon_tick) else $error("fault set off the tick");
  a_tick_period: assert property (
    mon_tick |-> ##TICK_CYCLES mon_tick) else $error("monitor tick period wrong");
  a_hiz_fall: assert property (
    $fell(ext_oc_n) |=> pwm_hiz && gate_en == '0) else $error("hi-z missed on fault edge");
  a_hiz_short: assert property (
    short_detect |=> pwm_hiz && gate_en == '0) else $error("hi-z missed on short");
  a_latch_hold: assert property (
    (fault_flags != '0 || pwm_hiz) && !fault_clear
    |=> gate_en == '0 && (fault_flags & $past(fault_flags)) == $past(fault_flags)) else $error("fault not held");
  a_error_state: assert property (
    $rose(|fault_flags) && !fault_clear |=> sys_state == 2'd2) else $error("error state not entered");
  a_gate_same: assert property (
    (gate_en == '0 || gate_en == '1) && motor_run == gate_en[0]) else $error("gate outputs disagree");
  a_dead_band: assert property (
    1'b1 |=> pos_err_db == (($past(pos_err_cnt) > 16'sd1 || $past(pos_err_cnt) < -16'sd1) ?
    $past(pos_err_cnt) : 16'sh0)) else $error("dead band wrong");
  c_fault: cover property (fault_flags[FLT_OS]);
  c_hiz: cover property (pwm_hiz);
  c_run_stop: cover property (motor_run ##1 !motor_run);
endmodule
bind mps_top mps_top_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_mps_top_assertions (.mclk, .arst_n,
  .fault_clear, .ext_oc_n, .short_detect, .rotor_speed_rpm, .pos_err_cnt, .gate_en, .pwm_hiz,
  .motor_run, .sys_state, .fault_flags, .mon_tick, .vbus_mv, .iu_ma, .iw_ma, .pos_err_db);
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the motor supervisor.
// Assumes the board model drives codes, switch and fault lines.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("CHECK FAILED %s exp %0d got %0d", n, e, g); \
    end \
  end
module tb_top;
  import mps_pkg::*;
  localparam int TCK = 20;
  logic mclk, arst_n, adc_valid, sw, oc_n, shrt, host_start, host_stop, fault_clear, pwm_hiz, motor_run;
  logic mon_tick, cmd_ccw;
  logic [11:0] cmd_c, vb_c, iu_c, iw_c, cmd_speed_rpm;
  logic signed [15:0] rotor_speed_rpm, pos_err_cnt, cmd_angle_cdeg, iu_ma, iw_ma, pos_err_db;
  logic [GATE_N-1:0] gate_en;
  logic [1:0] sys_state;
  logic [FLT_W-1:0] fault_flags;
  logic [16:0] vbus_mv;
  int mismatches = 0;
  int tests_run = 0;
  int edge_c[4] = '{0, 2047, 2048, 4095};
  int ok_v[4] = '{2673, 1033, 517, 3000};
  int bad_v[4] = '{2674, 1034, 516, 3001};
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  mps_board_model i_mps_board_model (.mclk(mclk), .adc_valid(adc_valid), .cmd_code(cmd_c), .vbus_code(vb_c),
    .iu_code(iu_c), .iw_code(iw_c), .sw(sw), .oc_n(oc_n), .shrt(shrt));
  mps_top #(.TICK_CYCLES(TCK)) i_mps_top (.mclk(mclk), .arst_n(arst_n), .adc_valid(adc_valid),
    .command_input_channel(cmd_c), .bus_voltage_channel(vb_c), .phase_u_current_channel(iu_c),
    .phase_w_current_channel(iw_c), .rotor_speed_rpm(rotor_speed_rpm), .pos_err_cnt(pos_err_cnt),
    .start_stop_switch(sw), .host_start(host_start), .host_stop(host_stop), .fault_clear(fault_clear),
    .ext_oc_n(oc_n), .short_detect(shrt), .gate_en(gate_en), .pwm_hiz(pwm_hiz), .motor_run(motor_run),
    .sys_state(sys_state), .fault_flags(fault_flags), .mon_tick(mon_tick), .cmd_angle_cdeg(cmd_angle_cdeg),
    .cmd_speed_rpm(cmd_speed_rpm), .cmd_ccw(cmd_ccw), .vbus_mv(vbus_mv), .iu_ma(iu_ma), .iw_ma(iw_ma),
    .pos_err_db(pos_err_db));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic tick_wait();
    int n;
    n = 0;
    cyc(1);
    while (mon_tick !== 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    if (n >= 100)
    begin
      mismatches++;
      complete_run();
    end
    cyc(3);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(3);
  endtask
  task automatic put(int c, int v, int u, int w);
    i_mps_board_model.put(c[11:0], v[11:0], u[11:0], w[11:0]);
    cyc(8);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    int r[4];
    int off;
    {arst_n, host_start, host_stop, fault_clear, rotor_speed_rpm, pos_err_cnt} = '0;
    void'($urandom(32'h776c));
    cyc(12);
    arst_n = 1'b1;
    tick_wait();
    pulse(fault_clear);
    for (int i = 0; i < 12; i++)
    begin
      foreach (r[j]) r[j] = i < 4 ? edge_c[i] : int'($urandom_range(4095));
      i_mps_board_model.gap = (i % 2) * 3;
      put(r[0], r[1], r[2], r[3]);
      off = r[0] < 2048 ? 2047 - r[0] : r[0] - 2048;
      `CHK("angle", r[0] < 2048 ? off * 18000 / 2047 : -(off * 18000 / 2047), cmd_angle_cdeg)
      `CHK("speed", off * 2000 / 2047, cmd_speed_rpm)
      `CHK("ccw", r[0] >= 2048, cmd_ccw)
      `CHK("vbus", r[1] * 111000 / 4095, vbus_mv)
      `CHK("iu", r[2] * 25000 / 4095 - 12500, iu_ma)
      `CHK("iw", r[3] * 25000 / 4095 - 12500, iw_ma)
    end
    i_mps_board_model.gap = 0;
    put(12'h7ff, 12'h2e2, 12'h800, 12'h7ff);
    tick_wait();
    pulse(fault_clear);
    $display("test scaling done");
    i_mps_board_model.sw = 1'b0;
    tick_wait();
    `CHK("switch start", 63, gate_en)
    `CHK("active state", 1, sys_state)
    i_mps_board_model.sw = 1'b1;
    tick_wait();
    `CHK("switch stop", 0, gate_en)
    pulse(host_start);
    `CHK("host start", 1, motor_run)
    pulse(host_stop);
    `CHK("host stop", 0, motor_run)
    $display("test start_stop done");
    for (int k = 0; k < 4; k++)
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (b == 0)
          pulse(host_start);
        off = b ? bad_v[k] : ok_v[k];
        if (k == 3)
          rotor_speed_rpm = off[15:0];
        else
          put(12'h7ff, k ? off : 12'h2e2, k ? 12'h800 : off, 12'h7ff);
        tick_wait();
        `CHK("trip flags", b << k, fault_flags)
        `CHK("trip gates", b ? 0 : 63, gate_en)
      end
      `CHK("error state", 2, sys_state)
      rotor_speed_rpm = '0;
      put(12'h7ff, 12'h2e2, 12'h800, 12'h7ff);
      tick_wait();
      `CHK("still latched", 0, gate_en)
      pulse(fault_clear);
      `CHK("cleared", 0, fault_flags)
    end
    $display("test protection done");
    pulse(host_start);
    i_mps_board_model.oc_n = 1'b0;
    cyc(2);
    `CHK("hiz on fault edge", 1, pwm_hiz)
    `CHK("hiz gates", 0, gate_en)
    i_mps_board_model.oc_n = 1'b1;
    pulse(fault_clear);
    `CHK("hiz cleared", 0, pwm_hiz)
    pulse(i_mps_board_model.shrt);
    `CHK("hiz on short", 1, pwm_hiz)
    pulse(fault_clear);
    $display("test hiz done");
    for (int p = -3; p < 4; p++)
    begin
      pos_err_cnt = p[15:0];
      cyc(1);
      `CHK("dead band", (p > 1 || p < -1) ? p : 0, pos_err_db)
    end
    $display("test dead_band done");
    complete_run();
  end
  // Cuts a hang short at roughly forty times the expected run length
  initial
  begin
    #(TCK * 10 * 1000);
    mismatches++;
    $display("watchdog expired");
    complete_run();
  end
endmodule
`default_nettype wire
